// >>> rtl/mas_pkg.sv
// Constants, register map and state type for the monitor converter sequencer
// Summary of operation
// R1: Host waits 210 us after buffer power-up before setting the trigger.
// R2: An early trigger is held off until the power-up timer expires.
// R3: Power-down mid-run waits timer, drops enable, ends slot, powers off; the sequencer drops enable at once, without waiting.
// R4: No conversion starts unless the trigger bit is set.
// R5: Method bit 1 selects one-shot, 0 continuous; continuous after reset.
// R6: One-shot converts start to stop once, goes idle, self-clears trigger.
// R7: Continuous restarts from start index right after the last slot.
// R8: Continuous stops after the current slot when trigger is written 0.
// R9: Results hold latest conversion per slot; reads never disturb conversion.
// R10: Host changes configuration only while busy is low.
// R11: Sixteen slots in fixed order bounded by start and stop indices.
// R12: Slot 0 offset, 1-2 external, 3 die temp, 4-8 diagnostics, 9-15 ground.
// R13: Equal indices convert one slot; different indices cycle between them.
// R14: Start index resets to 0 and stop index to 8.
// R15: Start above stop behaves as if stop equalled start.
// R16: Unconfigured second external input reads 0x000 but still uses its slot.
// R17: Converter clock is oscillator over 16; conversion needs 20 or more.
// R18: Internal slots run at 2560 Hz; only external slots use rate and range.
// R19: Low supply detected blocks the wide-range bit, forcing narrow range.
// R20: Busy flag in general status is high while converting, low when idle.
// R21: Reset leaves sequencer idle, trigger clear, busy low, pointer at start.
package mas_pkg;
  localparam int CLK_HZ = 100000000;
  localparam int OSC_HZ = 1228800;
  localparam int OSC_DIV = 16;
  localparam int ADC_TICK_CYCLES = (CLK_HZ / OSC_HZ) * OSC_DIV
    + ((CLK_HZ % OSC_HZ) * OSC_DIV) / OSC_HZ;
  localparam int PWRUP_US = 210;
  localparam int PWRUP_CYCLES_DEF = PWRUP_US * (CLK_HZ / 1000000);
  // Slot lengths in converter clocks per rate
  localparam logic [7:0] LEN_2560 = 8'h1E;
  localparam logic [7:0] LEN_640 = 8'h78;
  localparam logic [7:0] LEN_1280 = 8'h3C;
  localparam logic [7:0] LEN_3840 = 8'h14;
  localparam logic [3:0] SLOT_OFFSET = 4'h0;
  localparam logic [3:0] SLOT_EXT_A = 4'h1;
  localparam logic [3:0] SLOT_EXT_B = 4'h2;
  localparam logic [3:0] SLOT_DIAG_OUT = 4'h8;
  // Register byte addresses
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_INDEX = 8'h04;
  localparam logic [7:0] ADDR_TRIGGER = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_RESULT_BASE = 8'h40;
  // Configuration field positions
  localparam int CFG_PD_BIT = 0;
  localparam int CFG_ONESHOT_BIT = 1;
  localparam int CFG_RATE_LSB = 2;
  localparam int CFG_WIDE_BIT = 4;
  localparam int CFG_EXTB_BIT = 5;
  localparam int IDX_START_LSB = 0;
  localparam int IDX_STOP_LSB = 4;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_READY_BIT = 1;
  localparam int ST_SLOT_LSB = 4;
  // Reset values
  localparam logic RST_PD = 1'b1;
  localparam logic RST_ONESHOT = 1'b0;
  localparam logic [1:0] RST_RATE = 2'h0;
  localparam logic [3:0] RST_START = 4'h0;
  localparam logic [3:0] RST_STOP = 4'h8;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT_PWR = 2'b01,
    ST_CONVERT = 2'b11
  } mas_state_t;
endpackage

// >>> rtl/mas_sequencer.sv
// APB-controlled slot sequencer for the diagnostic SAR converter
`timescale 1ns/1ns
module mas_sequencer
  import mas_pkg::*;
#(
  parameter int PWRUP_CYCLES = PWRUP_CYCLES_DEF
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic low_supply_in,
  input wire logic [11:0] conv_data_in,
  output logic [3:0] mux_sel_out,
  output logic conv_start_out,
  output logic conv_range_wide_out,
  output logic conv_enable_out,
  output logic buf_enable_out,
  output logic busy_out
);
  mas_state_t state_q;
  logic pd_q;
  logic oneshot_q;
  logic [1:0] rate_q;
  logic wide_q;
  logic ext_b_q;
  logic [3:0] start_q;
  logic [3:0] stop_q;
  logic trig_q;
  logic [3:0] slot_q;
  logic [7:0] tick_cnt_q;
  logic [15:0] div_q;
  logic adc_tick;
  logic [31:0] pwr_cnt_q;
  logic timer_done;
  logic low_meta_q;
  logic low_sync_q;
  logic start_pulse_q;
  logic [11:0] result_q [16];
  logic [31:0] prdata_q;
  logic slverr_q;
  logic [3:0] stop_eff;
  logic [7:0] slot_len;
  logic slot_end;
  logic last_slot;
  logic wr_en;
  logic setup;
  logic addr_ok;
  logic run_stop;

  assign wr_en = psel_in && penable_in && pwrite_in;
  assign setup = psel_in && !penable_in;

  // Low-supply strap comes from the analog side
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      low_meta_q <= 1'b0;
      low_sync_q <= 1'b0;
    end else begin
      low_meta_q <= low_supply_in;
      low_sync_q <= low_meta_q;
    end
  end

  // Converter clock enable, oscillator over 16
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      div_q <= 16'h0000;
    end else if (div_q == 16'(ADC_TICK_CYCLES - 1)) begin // see R17
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end
  assign adc_tick = (div_q == 16'h0000);

  // Buffer power-up timer; runs while the buffer is requested on
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pwr_cnt_q <= 32'h0000_0000;
    end else if (pd_q && state_q == ST_IDLE) begin
      pwr_cnt_q <= 32'h0000_0000;
    end else if (!pd_q && pwr_cnt_q != 32'(PWRUP_CYCLES)) begin
      pwr_cnt_q <= pwr_cnt_q + 32'h0000_0001;
    end
  end
  assign timer_done = (pwr_cnt_q == 32'(PWRUP_CYCLES));
  // Enable rises only once the timer has run out and drops as soon as power-down is set
  assign conv_enable_out = timer_done && !pd_q; // see R3
  // Buffer stays powered until the running slot is done
  assign buf_enable_out = !pd_q || state_q == ST_CONVERT; // see R3

  // Configuration registers
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pd_q <= RST_PD;
      oneshot_q <= RST_ONESHOT; // see R5
      rate_q <= RST_RATE;
      wide_q <= 1'b0;
      ext_b_q <= 1'b0;
      start_q <= RST_START; // see R14
      stop_q <= RST_STOP; // see R14
    end else begin
      if (wr_en && paddr_in == ADDR_CFG) begin
        pd_q <= pwdata_in[CFG_PD_BIT];
        oneshot_q <= pwdata_in[CFG_ONESHOT_BIT]; // see R5
        rate_q <= pwdata_in[CFG_RATE_LSB +: 2];
        wide_q <= pwdata_in[CFG_WIDE_BIT] && !low_sync_q; // see R19
        ext_b_q <= pwdata_in[CFG_EXTB_BIT];
      end else if (low_sync_q) begin
        wide_q <= 1'b0; // see R19
      end
      if (wr_en && paddr_in == ADDR_INDEX) begin
        start_q <= pwdata_in[IDX_START_LSB +: 4]; // see R11
        stop_q <= pwdata_in[IDX_STOP_LSB +: 4]; // see R11
      end
    end
  end

  // Start above stop collapses to a single slot
  assign stop_eff = (start_q > stop_q) ? start_q : stop_q; // see R15, R13

  // Internal nodes fixed; external inputs use the programmed rate
  always_comb begin
    slot_len = LEN_2560; // see R18
    if (slot_q == SLOT_EXT_A || slot_q == SLOT_EXT_B) begin
      unique case (rate_q)
        2'h0: slot_len = LEN_640;
        2'h1: slot_len = LEN_1280;
        2'h2: slot_len = LEN_2560;
        2'h3: slot_len = LEN_3840;
      endcase
    end
  end

  assign slot_end = state_q == ST_CONVERT && adc_tick
    && tick_cnt_q == slot_len - 8'h01; // see R17
  assign last_slot = (slot_q == stop_eff);
  // Stop after this slot: trigger withdrawn, power-down, or one-shot end
  assign run_stop = !trig_q || !conv_enable_out
    || (oneshot_q && last_slot); // see R8, R3, R6

  // Range select: external slots programmable, output monitor by supply
  always_comb begin
    conv_range_wide_out = 1'b0; // see R18
    if (slot_q == SLOT_EXT_A || slot_q == SLOT_EXT_B) begin
      conv_range_wide_out = wide_q; // see R19
    end else if (slot_q == SLOT_DIAG_OUT) begin
      conv_range_wide_out = !low_sync_q;
    end
  end

  // Sequencer state machine
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= ST_IDLE; // see R21
      slot_q <= RST_START; // see R21
      tick_cnt_q <= 8'h00;
      start_pulse_q <= 1'b0;
    end else begin
      start_pulse_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          slot_q <= start_q;
          if (trig_q) begin // see R4
            state_q <= ST_WAIT_PWR;
          end
        end
        ST_WAIT_PWR: begin
          // Early trigger is parked here until the buffer settles
          if (!trig_q) begin
            state_q <= ST_IDLE;
          end else if (conv_enable_out) begin // see R2
            state_q <= ST_CONVERT;
            slot_q <= start_q;
            tick_cnt_q <= 8'h00;
            start_pulse_q <= 1'b1;
          end
        end
        ST_CONVERT: begin
          if (adc_tick) begin
            tick_cnt_q <= tick_cnt_q + 8'h01;
          end
          if (slot_end) begin
            tick_cnt_q <= 8'h00;
            if (run_stop) begin
              state_q <= ST_IDLE;
              slot_q <= start_q;
            end else begin
              slot_q <= last_slot ? start_q : slot_q + 4'h1; // see R7, R13
              start_pulse_q <= 1'b1;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign mux_sel_out = slot_q; // see R12
  assign conv_start_out = start_pulse_q;
  assign busy_out = (state_q != ST_IDLE); // see R20

  // Trigger bit: hardware clear loses to a same-cycle software set
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      trig_q <= 1'b0; // see R21
    end else if (wr_en && paddr_in == ADDR_TRIGGER) begin
      trig_q <= pwdata_in[0]; // see R8
    end else if (slot_end && run_stop) begin
      trig_q <= 1'b0; // see R6
    end else if (state_q == ST_WAIT_PWR && pd_q) begin
      trig_q <= 1'b0;
    end
  end

  // Results captured at slot end; bus reads never touch this path
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < 16; i++) begin
        result_q[i] <= 12'h000;
      end
    end else if (slot_end) begin
      if (slot_q == SLOT_EXT_B && !ext_b_q) begin
        result_q[slot_q] <= 12'h000; // see R16
      end else begin
        result_q[slot_q] <= conv_data_in; // see R9
      end
    end
  end

  // APB read data latched in setup, answered with no wait state
  assign addr_ok = paddr_in[1:0] == 2'b00 && (paddr_in <= ADDR_STATUS
    || paddr_in[7:6] == ADDR_RESULT_BASE[7:6]);
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= 32'h0000_0000;
      slverr_q <= !addr_ok;
      if (paddr_in == ADDR_CFG) begin
        prdata_q[CFG_PD_BIT] <= pd_q;
        prdata_q[CFG_ONESHOT_BIT] <= oneshot_q;
        prdata_q[CFG_RATE_LSB +: 2] <= rate_q;
        prdata_q[CFG_WIDE_BIT] <= wide_q;
        prdata_q[CFG_EXTB_BIT] <= ext_b_q;
      end else if (paddr_in == ADDR_INDEX) begin
        prdata_q[IDX_START_LSB +: 4] <= start_q;
        prdata_q[IDX_STOP_LSB +: 4] <= stop_q;
      end else if (paddr_in == ADDR_TRIGGER) begin
        prdata_q[0] <= trig_q;
      end else if (paddr_in == ADDR_STATUS) begin
        prdata_q[ST_BUSY_BIT] <= busy_out; // see R20
        prdata_q[ST_READY_BIT] <= conv_enable_out;
        prdata_q[ST_SLOT_LSB +: 4] <= slot_q;
      end else if (addr_ok) begin
        prdata_q[11:0] <= result_q[paddr_in[5:2]]; // see R9
      end
    end
  end
  assign prdata_out = prdata_q;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && slverr_q;

  // Checks
  property p_start_powered;
    @(posedge clk_in) disable iff (reset_in)
    conv_start_out |-> timer_done;
  endproperty
  a_start_powered: assert property (p_start_powered) // see R2
    else $error("Conversion started before power-up timer expired");

  property p_no_trig_no_start;
    @(posedge clk_in) disable iff (reset_in)
    (state_q == ST_IDLE && !trig_q) |=> !conv_start_out;
  endproperty
  a_no_trig_no_start: assert property (p_no_trig_no_start) // see R4
    else $error("Conversion started without trigger");

  property p_oneshot_done;
    @(posedge clk_in) disable iff (reset_in)
    (slot_end && oneshot_q && last_slot && !wr_en)
      |=> (state_q == ST_IDLE && !trig_q);
  endproperty
  a_oneshot_done: assert property (p_oneshot_done) // see R6
    else $error("One-shot did not end idle with trigger cleared");

  property p_cont_wrap;
    @(posedge clk_in) disable iff (reset_in)
    (slot_end && !oneshot_q && last_slot && trig_q && conv_enable_out)
      |=> (slot_q == $past(start_q) && conv_start_out);
  endproperty
  a_cont_wrap: assert property (p_cont_wrap) // see R7
    else $error("Continuous run did not restart at start index");

  property p_cont_stop;
    @(posedge clk_in) disable iff (reset_in)
    (slot_end && !trig_q) |=> (state_q == ST_IDLE) ##1 !conv_start_out;
  endproperty
  a_cont_stop: assert property (p_cont_stop) // see R8
    else $error("Converter kept running after trigger cleared");

  property p_result_ext_a;
    @(posedge clk_in) disable iff (reset_in)
    (slot_end && slot_q == SLOT_EXT_A)
      |=> result_q[SLOT_EXT_A] == $past(conv_data_in);
  endproperty
  a_result_ext_a: assert property (p_result_ext_a) // see R9
    else $error("Result not stored at slot end");

  property p_ext_b_zero;
    @(posedge clk_in) disable iff (reset_in)
    (slot_end && slot_q == SLOT_EXT_B && !ext_b_q)
      |=> result_q[SLOT_EXT_B] == 12'h000;
  endproperty
  a_ext_b_zero: assert property (p_ext_b_zero) // see R16
    else $error("Unconfigured external input result not zero");

  property p_wide_blocked;
    @(posedge clk_in) disable iff (reset_in)
    (low_sync_q && $past(low_sync_q)) |-> !wide_q;
  endproperty
  a_wide_blocked: assert property (p_wide_blocked) // see R19
    else $error("Wide range set under low supply");

  property p_internal_narrow;
    @(posedge clk_in) disable iff (reset_in)
    (state_q == ST_CONVERT && slot_q != SLOT_EXT_A && slot_q != SLOT_EXT_B
      && slot_q != SLOT_DIAG_OUT)
      |-> !conv_range_wide_out && slot_len == LEN_2560;
  endproperty
  a_internal_narrow: assert property (p_internal_narrow) // see R18
    else $error("Internal slot not at fixed rate and range");

  property p_single_slot;
    @(posedge clk_in) disable iff (reset_in)
    (start_q >= stop_q && state_q == ST_CONVERT) |-> slot_q == start_q;
  endproperty
  a_single_slot: assert property (p_single_slot) // see R15
    else $error("Pointer left start slot with start not below stop");

  property p_busy_on_start;
    @(posedge clk_in) disable iff (reset_in)
    conv_start_out |-> busy_out;
  endproperty
  a_busy_on_start: assert property (p_busy_on_start) // see R20
    else $error("Busy low while a slot is starting");

  property p_slot_hold;
    @(posedge clk_in) disable iff (reset_in)
    (state_q == ST_CONVERT && !slot_end) |=> slot_q == $past(slot_q);
  endproperty
  a_slot_hold: assert property (p_slot_hold) // see R11
    else $error("Slot pointer moved inside a slot");

  property p_slot_range;
    @(posedge clk_in) disable iff (reset_in)
    (state_q == ST_CONVERT) |-> slot_q >= start_q && slot_q <= stop_eff;
  endproperty
  a_slot_range: assert property (p_slot_range) // see R13
    else $error("Slot pointer outside start and stop bounds");

  property p_pd_finish;
    @(posedge clk_in) disable iff (reset_in)
    (pd_q && state_q == ST_CONVERT) |-> !conv_enable_out && buf_enable_out;
  endproperty
  a_pd_finish: assert property (p_pd_finish) // see R3
    else $error("Power-down did not let the running slot finish");

  property p_min_len;
    @(posedge clk_in) disable iff (reset_in)
    slot_end |-> tick_cnt_q >= LEN_3840 - 8'h01;
  endproperty
  a_min_len: assert property (p_min_len) // see R17
    else $error("Slot ended before twenty converter clocks");
endmodule

// >>> tb/monitor_adc_sequencer_test.sv
// Self-checking bench for the converter slot sequencer over APB
`timescale 1ns/1ns
module monitor_adc_sequencer_test
  import mas_pkg::*;
();
  localparam int PWRUP_SIM = 50;
  localparam int TIMEOUT = 99000;
  localparam int T = ADC_TICK_CYCLES;
  logic clk_in;
  logic reset_in;
  logic [7:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic low_supply_in;
  logic [11:0] conv_data_in;
  logic [3:0] mux_sel_out;
  logic conv_start_out;
  logic conv_range_wide_out;
  logic conv_enable_out;
  logic buf_enable_out;
  logic busy_out;
  logic [31:0] rd;
  logic er;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n_starts = 0;
  int start_cyc = 0;
  int t0;

  mas_sequencer #(.PWRUP_CYCLES(PWRUP_SIM)) dut_u (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .paddr_in(paddr),
    .psel_in(psel),
    .penable_in(penable),
    .pwrite_in(pwrite),
    .pwdata_in(pwdata),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .low_supply_in(low_supply_in),
    .conv_data_in(conv_data_in),
    .mux_sel_out(mux_sel_out),
    .conv_start_out(conv_start_out),
    .conv_range_wide_out(conv_range_wide_out),
    .conv_enable_out(conv_enable_out),
    .buf_enable_out(buf_enable_out),
    .busy_out(busy_out)
  );

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic finish_test();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp,
                           input string msg);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, msg, got,
               exp);
    end
  endtask

  task automatic check_rng(input int got, input int lo, input int hi,
                           input string msg);
    cmp_count++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %0d range %0d..%0d", $time, msg,
               got, lo, hi);
    end
  endtask

  // Request held until pready is seen; data taken at that edge only
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Slot start monitor and hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (conv_start_out === 1'b1) begin
      start_cyc <= cyc;
      n_starts <= n_starts + 1;
    end
    if (cyc == TIMEOUT) begin
      n_errors++;
      $display("CHECK FAILED at %0t: timeout", $time);
      finish_test();
    end
  end

  initial begin
    reset_in = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    low_supply_in = 1'b0;
    conv_data_in = 12'h5A5;
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    check_val({busy_out, mux_sel_out}, {1'b0, RST_START}, "idle");
    apb(1'b0, ADDR_CFG, 32'h0);
    check_val(rd, (32'(RST_PD) << CFG_PD_BIT) |
      (32'(RST_ONESHOT) << CFG_ONESHOT_BIT), "cfg reset");
    apb(1'b0, ADDR_INDEX, 32'h0);
    check_val(rd, {24'h0, RST_STOP, RST_START}, "index reset");
    apb(1'b0, ADDR_TRIGGER, 32'h0);
    check_val(rd, 32'h0, "trigger reset");
    apb(1'b0, ADDR_STATUS, 32'h0);
    check_val(rd[ST_BUSY_BIT], 1'b0, "status busy reset");
    apb(1'b0, 8'h20, 32'h0);
    check_val(er, 1'b1, "unmapped error");
    check_val(rd, 32'h0, "unmapped read");
    check_rng(n_starts, 0, 0, "no start untriggered");
    // One-shot, start above stop, early trigger, power-down mid slot
    apb(1'b1, ADDR_INDEX, 32'h12);
    t0 = cyc;
    apb(1'b1, ADDR_CFG, 32'h1E);
    apb(1'b1, ADDR_TRIGGER, 32'h1);
    wait (n_starts == 1);
    check_rng(start_cyc - t0, PWRUP_SIM, PWRUP_SIM + 12, "hold-off");
    check_val(mux_sel_out, SLOT_EXT_B, "slot ext b");
    check_val(conv_range_wide_out, 1'b1, "ext range wide");
    repeat (100) @(posedge clk_in);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check_val(rd & 32'hF1, (32'(SLOT_EXT_B) << ST_SLOT_LSB) |
      (32'h1 << ST_BUSY_BIT), "status busy");
    apb(1'b1, ADDR_CFG, 32'h1F);
    repeat (2) @(posedge clk_in);
    check_val(conv_enable_out, 1'b0, "enable dropped");
    check_val({busy_out, buf_enable_out}, 2'b11, "slot finishing");
    wait (busy_out === 1'b0);
    check_rng(cyc - start_cyc, 19 * T - 4, 20 * T + 4, "slot len");
    repeat (3) @(posedge clk_in);
    check_val(buf_enable_out, 1'b0, "buffer off");
    check_rng(n_starts, 1, 1, "one pass");
    apb(1'b0, ADDR_TRIGGER, 32'h0);
    check_val(rd, 32'h0, "trigger self-clear");
    apb(1'b0, ADDR_RESULT_BASE + 8'h08, 32'h0);
    check_val(rd, 32'h0, "unconfigured input");
    // Continuous single slot under low supply, stopped by trigger 0
    low_supply_in <= 1'b1;
    conv_data_in <= 12'hABC;
    repeat (4) @(posedge clk_in);
    check_val(busy_out, 1'b0, "idle before config");
    apb(1'b1, ADDR_INDEX, 32'h11);
    apb(1'b1, ADDR_CFG, 32'h1C);
    apb(1'b0, ADDR_CFG, 32'h0);
    check_val(rd, 32'h0C, "wide bit blocked");
    repeat (PWRUP_SIM) @(posedge clk_in);
    check_val(conv_enable_out, 1'b1, "powered before trigger");
    apb(1'b1, ADDR_TRIGGER, 32'h1);
    wait (n_starts == 2);
    check_val(mux_sel_out, SLOT_EXT_A, "single slot");
    check_val(conv_range_wide_out, 1'b0, "narrow forced");
    t0 = start_cyc;
    wait (n_starts == 3);
    check_rng(start_cyc - t0, 19 * T - 4, 20 * T + 4, "restart");
    check_val({busy_out, mux_sel_out}, {1'b1, SLOT_EXT_A}, "wrap");
    apb(1'b0, ADDR_RESULT_BASE + 8'h04, 32'h0);
    check_val(rd, 32'hABC, "result ext a");
    apb(1'b1, ADDR_TRIGGER, 32'h0);
    repeat (4) @(posedge clk_in);
    check_val(busy_out, 1'b1, "current slot runs on");
    wait (busy_out === 1'b0);
    check_rng(cyc - start_cyc, 19 * T - 4, 20 * T + 4, "stop end");
    repeat (50) @(posedge clk_in);
    check_rng(n_starts, 3, 3, "no start after stop");
    finish_test();
  end
endmodule
